// ==== logic/tps_pkg.sv ====
// Shared constants and carrier types of the trigger preset sequencer
package tps_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam int             ADDR_W         = 8;
  localparam logic [7:0]     REG_CTRL       = 8'h00;
  localparam logic [7:0]     REG_CMD_INDEX  = 8'h04;
  localparam logic [7:0]     REG_STATUS     = 8'h08;
  localparam logic [7:0]     REG_COMMIT     = 8'h0C;
  localparam logic [7:0]     REG_LIVE_BASE  = 8'h20;
  localparam logic [7:0]     REG_STAGE_BASE = 8'h40;
  localparam int             FIELD_WORDS    = 8;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int             CTRL_MODE_LSB    = 0;
  localparam int             CTRL_CURVE_BIT   = 2;
  localparam int             CTRL_RESTART_BIT = 3;
  localparam int             MISC_BIN_H       = 0;
  localparam int             MISC_BIN_V       = 1;
  localparam int             MISC_CURVE       = 2;
  localparam int             MISC_REPEAT_LSB  = 8;
  localparam int             MISC_NEXT_LSB    = 16;
  localparam int             STAT_PTR_LSB     = 0;
  localparam int             STAT_REPS_LSB    = 8;
  localparam int             STAT_BUSY_BIT    = 16;

  // ****************************************************************
  // Limits and reset values
  // ****************************************************************
  localparam int             PRESETS        = 128;
  localparam logic [7:0]     FIRST_PRESET   = 8'h01;
  localparam logic [7:0]     LAST_PRESET    = 8'h80;
  localparam logic [15:0]    MIN_W_MONO     = 16'h0060;
  localparam logic [15:0]    MIN_W_MONO_BIN = 16'h0030;
  localparam logic [15:0]    MIN_W_COLOUR   = 16'h0010;
  localparam logic [15:0]    MIN_H          = 16'h0002;
  localparam logic [15:0]    RST_WIDTH      = 16'h0790;
  localparam logic [15:0]    RST_HEIGHT     = 16'h04C0;
  localparam logic [1:0]     RESP_OKAY      = 2'h0;
  localparam logic [1:0]     RESP_SLVERR    = 2'h2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_NORMAL    = 2'h0,
    MODE_CHAIN     = 2'h1,
    MODE_COMMANDED = 2'h2
  } tps_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_LATCH  = 2'h1,
    ST_ACTIVE = 2'h3
  } tps_state_t;

  typedef struct packed {
    logic [15:0] width;
    logic [15:0] height;
    logic [15:0] off_x;
    logic [15:0] off_y;
    logic [31:0] exposure;
    logic [15:0] gain;
    logic [15:0] black;
    logic        bin_h;
    logic        bin_v;
    logic        curve_flag;
    logic [7:0]  repeat_cnt;
    logic [7:0]  next_index;
  } tps_preset_t;

  typedef struct packed {
    logic [15:0] width;
    logic [15:0] height;
    logic [15:0] off_x;
    logic [15:0] off_y;
    logic [31:0] exposure;
    logic [15:0] gain;
    logic [15:0] black;
    logic        bin_h;
    logic        bin_v;
    logic        use_lut;
  } tps_frame_t;

endpackage

// ==== logic/tps_sequencer.sv ====
// Trigger preset sequencer with region crop, 2x2 binning and AXI4-Lite registers
//
// What this block does
// RULE_01 - Horizontal binning sums each pair of neighbouring pixels into one.
// RULE_02 - Both binnings on sum a 2x2 group into one pixel.
// RULE_03 - Only the configured rectangle of width, height and offsets is output.
// RULE_04 - Only lines inside the region height are scanned; frame ends there.
// RULE_05 - Monochrome minimum width is 96, or 48 with horizontal binning on.
// RULE_06 - Colour minimum width is 16; minimum height is 2 lines on both.
// RULE_07 - Each binning factor is either 1 or 2.
// RULE_08 - Mode selector offers normal, chained presets and host-commanded preset.
// RULE_09 - Up to 128 presets hold region, exposure, gain, black, binning, curve flag.
// RULE_10 - Chained presets also carry a repeat count and successor number.
// RULE_11 - The chained pattern always starts at preset 1.
// RULE_12 - After repeat-count triggers move to successor; successor 1 loops back.
// RULE_13 - Restart command sets the pointer back to preset 1.
// RULE_14 - Curve source picks global gamma, or lookup curve where preset flag set.
// RULE_15 - Host writes commanded preset number 1 to 128.
// RULE_16 - Commanded mode reuses one preset until the commanded number changes.
// RULE_17 - Commanded mode ignores repeat counts, successors and restart.
// RULE_18 - Normal mode uses the live settings and no preset.
// RULE_19 - Settings are latched on trigger and held for the whole frame.
`timescale 1ns/100ps

module tps_sequencer #(
  parameter int PIX_W  = 10,
  parameter int MAX_W  = 1936,
  parameter bit COLOUR = 1'b0
) (
  // Clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // AXI4-Lite register slave
  input  wire logic [7:0]          s_axil_awaddr,
  input  wire logic                s_axil_awvalid,
  output logic                     s_axil_awready,
  input  wire logic [31:0]         s_axil_wdata,
  input  wire logic [3:0]          s_axil_wstrb,
  input  wire logic                s_axil_wvalid,
  output logic                     s_axil_wready,
  output logic [1:0]               s_axil_bresp,
  output logic                     s_axil_bvalid,
  input  wire logic                s_axil_bready,
  input  wire logic [7:0]          s_axil_araddr,
  input  wire logic                s_axil_arvalid,
  output logic                     s_axil_arready,
  output logic [31:0]              s_axil_rdata,
  output logic [1:0]               s_axil_rresp,
  output logic                     s_axil_rvalid,
  input  wire logic                s_axil_rready,
  // Trigger
  input  wire logic                trigger_in,
  // Sensor pixel stream
  input  wire logic                sen_valid,
  input  wire logic [PIX_W-1:0]    sen_data,
  input  wire logic                sen_sof,
  input  wire logic                sen_eol,
  // Frame settings to readout
  output tps_pkg::tps_frame_t      frame_cfg,
  output logic                     exposure_start,
  output logic                     frame_done,
  // Processed pixel stream
  output logic                     pix_valid,
  output logic [PIX_W+1:0]         pix_data,
  output logic                     pix_eol
);

  localparam int CW = $clog2(MAX_W);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  if (PIX_W < 1 || PIX_W > 16 || MAX_W < 96 || MAX_W > 65535)
  begin : g_bad_param
    $error("tps_sequencer: PIX_W or MAX_W out of range");
  end

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == tps_pkg::REG_CTRL || a == tps_pkg::REG_CMD_INDEX || a == tps_pkg::REG_STATUS
        || a == tps_pkg::REG_COMMIT
        || (a[1:0] == 2'h0 && a >= tps_pkg::REG_LIVE_BASE && a < tps_pkg::REG_LIVE_BASE + 8'h20)
        || (a[1:0] == 2'h0 && a >= tps_pkg::REG_STAGE_BASE && a < tps_pkg::REG_STAGE_BASE + 8'h20);
  endfunction

  // Out-of-range numbers fall back to the pattern start
  function automatic logic [7:0] norm_index(input logic [7:0] v);
    return (v < tps_pkg::FIRST_PRESET || v > tps_pkg::LAST_PRESET) ? tps_pkg::FIRST_PRESET : v;
  endfunction

  function automatic tps_pkg::tps_preset_t unpack(input logic [8*32-1:0] w);
    tps_pkg::tps_preset_t p;
    logic [31:0] misc;
    misc         = w[7*32 +: 32];
    p.width      = w[0*32 +: 16];
    p.height     = w[1*32 +: 16];
    p.off_x      = w[2*32 +: 16];
    p.off_y      = w[3*32 +: 16];
    p.exposure   = w[4*32 +: 32];
    p.gain       = w[5*32 +: 16];
    p.black      = w[6*32 +: 16];
    p.bin_h      = misc[tps_pkg::MISC_BIN_H];
    p.bin_v      = misc[tps_pkg::MISC_BIN_V];
    p.curve_flag = misc[tps_pkg::MISC_CURVE];
    p.repeat_cnt = misc[tps_pkg::MISC_REPEAT_LSB +: 8];
    p.next_index = misc[tps_pkg::MISC_NEXT_LSB +: 8];
    return p;
  endfunction

  function automatic tps_pkg::tps_frame_t to_frame(input tps_pkg::tps_preset_t p,
                                                   input logic use_lut);
    tps_pkg::tps_frame_t f;
    logic [15:0] min_w;
    // RULE_07 binning factor 1 or 2; colour has no binning
    f.bin_h    = p.bin_h & ~COLOUR;
    f.bin_v    = p.bin_v & ~COLOUR;
    // RULE_05 monochrome width floor
    min_w      = f.bin_h ? tps_pkg::MIN_W_MONO_BIN : tps_pkg::MIN_W_MONO;
    // RULE_06 colour width and height floor
    if (COLOUR)
    begin
      min_w = tps_pkg::MIN_W_COLOUR;
    end
    f.width    = (p.width < min_w) ? min_w : p.width;
    f.height   = (p.height < tps_pkg::MIN_H) ? tps_pkg::MIN_H : p.height;
    f.off_x    = p.off_x;
    f.off_y    = p.off_y;
    f.exposure = p.exposure;
    f.gain     = p.gain;
    f.black    = p.black;
    f.use_lut  = use_lut;
    return f;
  endfunction

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  logic              aw_held;
  logic              w_held;
  logic [7:0]        aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              do_write;
  logic [31:0]       wr_val;
  tps_pkg::tps_mode_t mode;
  logic              curve_source;
  logic [7:0]        cmd_index;
  logic [31:0]       live_w  [tps_pkg::FIELD_WORDS];
  logic [31:0]       stage_w [tps_pkg::FIELD_WORDS];
  logic [8*32-1:0]   live_flat;
  logic [8*32-1:0]   stage_flat;
  logic              restart;
  logic              commit;
  logic [7:0]        ptr;
  logic [7:0]        reps;
  tps_pkg::tps_state_t state;

  assign s_axil_awready = !aw_held && !s_axil_bvalid;
  assign s_axil_wready  = !w_held && !s_axil_bvalid;
  assign s_axil_arready = !s_axil_rvalid;
  assign do_write       = aw_held && w_held && !s_axil_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end
    else if (do_write)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end
    else
    begin
      if (s_axil_awvalid && s_axil_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axil_awaddr;
      end
      if (s_axil_wvalid && s_axil_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axil_wdata;
        w_strb <= s_axil_wstrb;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axil_bvalid <= 1'b0;
      s_axil_bresp  <= tps_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axil_bvalid <= 1'b1;
      s_axil_bresp  <= mapped(aw_addr) ? tps_pkg::RESP_OKAY : tps_pkg::RESP_SLVERR;
    end
    else if (s_axil_bready)
    begin
      s_axil_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  assign wr_val  = merge(32'h0000_0000, w_data, w_strb);
  // RULE_13 restart pulse
  assign restart = do_write && aw_addr == tps_pkg::REG_CTRL && wr_val[tps_pkg::CTRL_RESTART_BIT];
  assign commit  = do_write && aw_addr == tps_pkg::REG_COMMIT;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode         <= tps_pkg::MODE_NORMAL;
      curve_source <= 1'b0;
      cmd_index    <= tps_pkg::FIRST_PRESET;
    end
    else if (do_write && aw_addr == tps_pkg::REG_CTRL && w_strb[0])
    begin
      // RULE_08 three-way selector; code 3 runs as normal
      mode         <= tps_pkg::tps_mode_t'(wr_val[tps_pkg::CTRL_MODE_LSB +: 2]);
      // RULE_14 sequence-wide curve source
      curve_source <= wr_val[tps_pkg::CTRL_CURVE_BIT];
    end
    else if (do_write && aw_addr == tps_pkg::REG_CMD_INDEX && w_strb[0])
    begin
      // RULE_15 host commanded number
      cmd_index <= wr_val[7:0];
    end
  end

  for (genvar i = 0; i < tps_pkg::FIELD_WORDS; i++)
  begin : g_fields
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        live_w[i]  <= (i == 0) ? {16'h0000, tps_pkg::RST_WIDTH}
                    : (i == 1) ? {16'h0000, tps_pkg::RST_HEIGHT} : 32'h0000_0000;
        stage_w[i] <= 32'h0000_0000;
      end
      else if (do_write)
      begin
        if (aw_addr == tps_pkg::REG_LIVE_BASE + 8'(4 * i))
        begin
          live_w[i] <= merge(live_w[i], w_data, w_strb);
        end
        if (aw_addr == tps_pkg::REG_STAGE_BASE + 8'(4 * i))
        begin
          stage_w[i] <= merge(stage_w[i], w_data, w_strb);
        end
      end
    end
    assign live_flat[i*32 +: 32]  = live_w[i];
    assign stage_flat[i*32 +: 32] = stage_w[i];
  end

  // ****************************************************************
  // Preset store
  // ****************************************************************
  tps_pkg::tps_preset_t preset_mem [tps_pkg::PRESETS];
  logic [7:0]           commit_idx;

  assign commit_idx = norm_index(wr_val[7:0]) - 8'h01;

  // RULE_09 commit staged fields into preset slot
  always_ff @(posedge aclk)
  begin
    if (commit)
    begin
      preset_mem[commit_idx[6:0]] <= unpack(stage_flat);
    end
  end

  // ****************************************************************
  // Register read
  // ****************************************************************
  function automatic logic [31:0] rd_value(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (a == tps_pkg::REG_CTRL)
    begin
      r[tps_pkg::CTRL_MODE_LSB +: 2]  = mode;
      r[tps_pkg::CTRL_CURVE_BIT]      = curve_source;
    end
    else if (a == tps_pkg::REG_CMD_INDEX)
    begin
      r[7:0] = cmd_index;
    end
    else if (a == tps_pkg::REG_STATUS)
    begin
      r[tps_pkg::STAT_PTR_LSB +: 8]  = ptr;
      r[tps_pkg::STAT_REPS_LSB +: 8] = reps;
      r[tps_pkg::STAT_BUSY_BIT]      = state != tps_pkg::ST_IDLE;
    end
    else if (a[7:5] == tps_pkg::REG_LIVE_BASE[7:5])
    begin
      r = live_w[a[4:2]];
    end
    else if (a[7:5] == tps_pkg::REG_STAGE_BASE[7:5])
    begin
      r = stage_w[a[4:2]];
    end
    return r;
  endfunction

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axil_rvalid <= 1'b0;
      s_axil_rdata  <= 32'h0000_0000;
      s_axil_rresp  <= tps_pkg::RESP_OKAY;
    end
    else if (s_axil_arvalid && s_axil_arready)
    begin
      s_axil_rvalid <= 1'b1;
      s_axil_rdata  <= mapped(s_axil_araddr) ? rd_value(s_axil_araddr) : 32'h0000_0000;
      s_axil_rresp  <= mapped(s_axil_araddr) ? tps_pkg::RESP_OKAY : tps_pkg::RESP_SLVERR;
    end
    else if (s_axil_rready)
    begin
      s_axil_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  tps_pkg::tps_mode_t   prev_mode;
  tps_pkg::tps_preset_t sel;
  tps_pkg::tps_frame_t  next_cfg;
  logic                 trig_ok;
  logic [7:0]           rep_limit;

  // RULE_19 triggers during a frame are ignored
  assign trig_ok   = trigger_in && state == tps_pkg::ST_IDLE;
  // RULE_16 commanded number picks the preset each trigger
  assign sel       = preset_mem[7'(norm_index(mode == tps_pkg::MODE_COMMANDED ? cmd_index : ptr)
                                   - 8'h01)];
  assign rep_limit = (sel.repeat_cnt == 8'h00) ? 8'h01 : sel.repeat_cnt;

  always_comb
  begin
    unique case (mode)
      tps_pkg::MODE_CHAIN, tps_pkg::MODE_COMMANDED:
        // RULE_14 lookup curve only where preset flag set
        next_cfg = to_frame(sel, curve_source & sel.curve_flag);
      default:
        // RULE_18 live set, no preset
        next_cfg = to_frame(unpack(live_flat), curve_source);
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ptr       <= tps_pkg::FIRST_PRESET;
      reps      <= 8'h00;
      prev_mode <= tps_pkg::MODE_NORMAL;
    end
    else
    begin
      prev_mode <= mode;
      // RULE_11 entering chain mode starts at preset 1
      // RULE_17 restart ignored in commanded mode
      if ((restart && mode != tps_pkg::MODE_COMMANDED)
          || (mode == tps_pkg::MODE_CHAIN && prev_mode != tps_pkg::MODE_CHAIN))
      begin
        ptr  <= tps_pkg::FIRST_PRESET;
        reps <= 8'h00;
      end
      else if (trig_ok && mode == tps_pkg::MODE_CHAIN)
      begin
        // RULE_10 RULE_12 repeat then follow successor
        if (reps + 8'h01 >= rep_limit)
        begin
          ptr  <= norm_index(sel.next_index);
          reps <= 8'h00;
        end
        else
        begin
          reps <= reps + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      frame_cfg <= '0;
    end
    else if (trig_ok)
    begin
      // RULE_19 latch settings at trigger
      frame_cfg <= next_cfg;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= tps_pkg::ST_IDLE;
    end
    else
    begin
      unique case (state)
        tps_pkg::ST_IDLE:   state <= trig_ok ? tps_pkg::ST_LATCH : tps_pkg::ST_IDLE;
        tps_pkg::ST_LATCH:  state <= tps_pkg::ST_ACTIVE;
        tps_pkg::ST_ACTIVE: state <= frame_done ? tps_pkg::ST_IDLE : tps_pkg::ST_ACTIVE;
        default:            state <= tps_pkg::ST_IDLE;
      endcase
    end
  end

  assign exposure_start = state == tps_pkg::ST_LATCH;

  // ****************************************************************
  // Region crop and binning
  // ****************************************************************
  logic [15:0]        x;
  logic [15:0]        y;
  logic [15:0]        x_cur;
  logic [15:0]        y_cur;
  logic [15:0]        rx;
  logic [15:0]        ry;
  logic [15:0]        col;
  logic               in_roi;
  logic               last_line;
  logic [PIX_W:0]     h_first;
  logic [PIX_W:0]     h_val;
  logic [PIX_W:0]     lbuf [MAX_W];

  assign x_cur  = sen_sof ? 16'h0000 : x;
  assign y_cur  = sen_sof ? 16'h0000 : y;
  assign rx     = x_cur - frame_cfg.off_x;
  assign ry     = y_cur - frame_cfg.off_y;
  // RULE_03 inside the rectangle only
  assign in_roi = state == tps_pkg::ST_ACTIVE && sen_valid
               && x_cur >= frame_cfg.off_x && rx < frame_cfg.width
               && y_cur >= frame_cfg.off_y && ry < frame_cfg.height;
  // RULE_04 frame ends after last region line
  assign last_line = state == tps_pkg::ST_ACTIVE && sen_valid && sen_eol
                  && y_cur >= frame_cfg.off_y && ry == frame_cfg.height - 16'h0001;
  // RULE_01 pair sum
  assign h_val  = frame_cfg.bin_h ? h_first + {1'b0, sen_data} : {1'b0, sen_data};
  assign col    = frame_cfg.bin_h ? {1'b0, rx[15:1]} : rx;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      x <= 16'h0000;
      y <= 16'h0000;
    end
    else if (sen_valid)
    begin
      x <= sen_eol ? 16'h0000 : x_cur + 16'h0001;
      y <= sen_eol ? y_cur + 16'h0001 : y_cur;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      h_first <= '0;
    end
    else if (in_roi && !rx[0])
    begin
      h_first <= {1'b0, sen_data};
    end
  end

  // RULE_02 even line parked for vertical sum
  always_ff @(posedge aclk)
  begin
    if (in_roi && frame_cfg.bin_v && !ry[0] && (!frame_cfg.bin_h || rx[0]))
    begin
      lbuf[col[CW-1:0]] <= h_val;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pix_valid  <= 1'b0;
      pix_data   <= '0;
      pix_eol    <= 1'b0;
      frame_done <= 1'b0;
    end
    else
    begin
      frame_done <= last_line;
      pix_valid  <= in_roi && (!frame_cfg.bin_h || rx[0]) && (!frame_cfg.bin_v || ry[0]);
      pix_eol    <= in_roi && rx == frame_cfg.width - 16'h0001;
      // RULE_02 four-pixel sum
      pix_data   <= frame_cfg.bin_v ? {1'b0, lbuf[col[CW-1:0]]} + {1'b0, h_val}
                                    : {1'b0, h_val};
    end
  end

endmodule

// ==== test/tps_checker.sv ====
// Port-level assertions for the trigger preset sequencer
`timescale 1ns/100ps
module tps_checker (
  // Clock and reset
  input wire logic           aclk,
  input wire logic           aresetn,
  // Register bus answers
  input wire logic           s_axil_bvalid,
  input wire logic           s_axil_bready,
  input wire logic           s_axil_rvalid,
  input wire logic           s_axil_rready,
  // Trigger, sensor and frame
  input wire logic           trigger_in,
  input wire logic           sen_valid,
  input wire logic           sen_eol,
  input tps_pkg::tps_frame_t frame_cfg,
  input wire logic           exposure_start,
  input wire logic           frame_done,
  input wire logic           pix_valid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_exp_after_trig: assert property (exposure_start |-> $past(trigger_in))
    else $error("exposure start without trigger");
  a_cfg_on_trig: assert property ($changed(frame_cfg) |-> exposure_start)
    else $error("frame settings moved mid frame");
  a_exp_one_cycle: assert property (exposure_start |=> !exposure_start)
    else $error("exposure start longer than one cycle");
  a_height_floor: assert property (exposure_start |-> frame_cfg.height >= tps_pkg::MIN_H)
    else $error("height below floor");
  // Mono build assumed; binned floor is the looser one
  a_width_floor: assert property (exposure_start |-> frame_cfg.width >=
    ((frame_cfg.bin_h || frame_cfg.bin_v) ? tps_pkg::MIN_W_MONO_BIN : tps_pkg::MIN_W_MONO))
    else $error("width below floor");
  a_pix_follows: assert property (pix_valid |-> $past(sen_valid))
    else $error("pixel out without sensor pixel");
  a_done_after_eol: assert property (frame_done |-> $past(sen_valid && sen_eol))
    else $error("frame end not after line end");
  a_b_holds: assert property (s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid)
    else $error("write answer dropped early");
  a_r_holds: assert property (s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid)
    else $error("read answer dropped early");
endmodule
bind tps_sequencer tps_checker u_chk (.*);

// ==== test/tps_sensor_model.sv ====
// Sensor readout model streaming one frame per exposure start
`timescale 1ns/100ps
module tps_sensor_model #(
  parameter int COLS = 128,
  parameter int ROWS = 4
) (
  // Clock and reset
  input  wire logic  aclk,
  input  wire logic  aresetn,
  // Frame request and stream
  input  wire logic  start,
  output logic       sen_valid,
  output logic [9:0] sen_data,
  output logic       sen_sof,
  output logic       sen_eol,
  output logic       idle
);
  int x;
  int y;
  assign idle = (y == ROWS);
  assign sen_valid = !idle;
  assign sen_sof = !idle && x == 0 && y == 0;
  assign sen_eol = !idle && x == COLS - 1;
  // Inverted level between frames so stale data never looks valid
  assign sen_data = idle ? 10'h3FC : 10'h003;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      y <= ROWS;
    else if (idle && start)
      y <= 0;
    else if (!idle && x == COLS - 1)
      y <= y + 1;
    x <= (idle || x == COLS - 1) ? 0 : x + 1;
  end
endmodule

// ==== test/tb_tps_sequencer.sv ====
// Self-checking bench for the trigger preset sequencer
`timescale 1ns/100ps
module tb_tps_sequencer;
  logic aclk, aresetn, trigger_in, sen_valid, sen_sof, sen_eol, sen_idle, pix_valid, pix_eol;
  logic s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready, s_axil_bvalid;
  logic s_axil_bready, s_axil_arvalid, s_axil_arready, s_axil_rvalid, s_axil_rready;
  logic [7:0] s_axil_awaddr, s_axil_araddr;
  logic [31:0] s_axil_wdata, s_axil_rdata;
  logic [3:0] s_axil_wstrb;
  logic [1:0] s_axil_bresp, s_axil_rresp;
  logic [9:0] sen_data;
  logic [11:0] pix_data, last_pix;
  logic exposure_start, frame_done, last_eol;
  tps_pkg::tps_frame_t frame_cfg;
  int n_fail = 0, total_checks = 0, pix_n;
  tps_sequencer u_dut (.*);
  tps_sensor_model u_sen (.aclk, .aresetn, .start(exposure_start), .sen_valid, .sen_data,
    .sen_sof, .sen_eol, .idle(sen_idle));
  always @(posedge aclk)
    if (exposure_start === 1'b1) pix_n <= 0;
    else if (pix_valid === 1'b1)
    begin
      pix_n <= pix_n + 1;
      last_pix <= pix_data;
      last_eol <= pix_eol;
    end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw, w;
    {aw, w} = 2'b00;
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    {s_axil_awvalid, s_axil_wvalid} <= 2'b11;
    while (!(aw && w))
    begin
      @(posedge aclk);
      if (s_axil_awready === 1'b1) aw = 1;
      if (s_axil_wready === 1'b1) w = 1;
      if (aw) s_axil_awvalid <= 0;
      if (w) s_axil_wvalid <= 0;
    end
    s_axil_bready <= 1;
    do @(posedge aclk); while (s_axil_bvalid !== 1'b1);
    s_axil_bready <= 0;
    chk(32'(s_axil_bresp), 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1;
    do @(posedge aclk); while (s_axil_arready !== 1'b1);
    {s_axil_arvalid, s_axil_rready} <= 2'b01;
    do @(posedge aclk); while (s_axil_rvalid !== 1'b1);
    s_axil_rready <= 0;
    chk(s_axil_rdata, ed);
    chk(32'(s_axil_rresp), 32'(er));
  endtask
  task automatic preset(input logic [7:0] n, input logic [15:0] w, input logic [31:0] m);
    logic [31:0] v [8];
    v = '{32'(w), 32'h2, 0, 0, 32'h10, 0, 0, m};
    for (int i = 0; i < 8; i++) wr(tps_pkg::REG_STAGE_BASE + 8'(4 * i), v[i]);
    wr(tps_pkg::REG_COMMIT, 32'(n));
  endtask
  // Trigger one frame, then compare its width, pixel count and last pixel
  task automatic shot(input logic [15:0] ew, input int en, input logic [11:0] ep);
    trigger_in <= 1;
    @(posedge aclk);
    trigger_in <= 0;
    repeat (3000) if (frame_done !== 1'b1) @(posedge aclk);
    @(negedge aclk);
    chk(32'(frame_cfg.width), 32'(ew));
    chk(pix_n, en);
    chk(32'(last_pix), 32'(ep));
    chk(32'(last_eol), 32'h1);
    do @(posedge aclk); while (sen_idle !== 1'b1);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    aclk = 0;
    forever #12.5 aclk = ~aclk;
  end
  initial
  begin
    #1000000;
    n_fail++;
    close_out();
  end
  initial
  begin
    {aresetn, trigger_in, s_axil_awvalid, s_axil_wvalid, s_axil_bready} = '0;
    {s_axil_arvalid, s_axil_rready, s_axil_awaddr, s_axil_araddr, s_axil_wdata} = '0;
    s_axil_wstrb = 4'hF;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    rd(tps_pkg::REG_LIVE_BASE, 32'h0000_0790, tps_pkg::RESP_OKAY);
    rd(8'hFC, 32'h0, tps_pkg::RESP_SLVERR);
    rd(tps_pkg::REG_CMD_INDEX, 32'h1, tps_pkg::RESP_OKAY);
    wr(tps_pkg::REG_LIVE_BASE, 32'h40);
    wr(tps_pkg::REG_LIVE_BASE + 8'h04, 32'h4);
    shot(16'h0060, 384, 12'h003);
    $display("test normal done");
    preset(8'h01, 16'h0064, 32'h0002_0204);
    preset(8'h02, 16'h006E, 32'h0001_0100);
    preset(8'h03, 16'h0064, 32'h0001_0103);
    preset(8'h04, 16'h0064, 32'h0001_0101);
    wr(tps_pkg::REG_CTRL, 32'h5);
    shot(16'h0064, 200, 12'h003);
    chk(32'(frame_cfg.use_lut), 32'h1);
    wr(tps_pkg::REG_CTRL, 32'hD);
    shot(16'h0064, 200, 12'h003);
    shot(16'h0064, 200, 12'h003);
    shot(16'h006E, 220, 12'h003);
    chk(32'(frame_cfg.use_lut), 32'h0);
    shot(16'h0064, 200, 12'h003);
    $display("test chain done");
    // Host picks 1 to 128 only
    wr(tps_pkg::REG_CMD_INDEX, 32'h3);
    wr(tps_pkg::REG_CTRL, 32'h2);
    shot(16'h0064, 50, 12'h00C);
    wr(tps_pkg::REG_CTRL, 32'hA);
    shot(16'h0064, 50, 12'h00C);
    wr(tps_pkg::REG_CMD_INDEX, 32'h4);
    shot(16'h0064, 100, 12'h006);
    $display("test commanded done");
    close_out();
  end
endmodule
